// >>> cpm_macrocell_array.sv
// Macrocell array: term allocation, output and input cells, MCU access
`timescale 1ns/1ns
`default_nettype none
module cpm_macrocell_array (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [cpm_pkg::NUM_TERMS-1:0] term_in,
   input wire logic cell_clock_pin,
   input wire logic ale,
   input wire logic [2:0] mcu_sel,
   input wire logic mcu_wr,
   input wire logic mcu_rd,
   input wire logic [7:0] mcu_wdata,
   output logic [7:0] mcu_rdata,
   input wire logic cfg_level_load,
   input wire logic [31:0] cfg_ff_type,
   input wire logic [15:0] cfg_invert,
   input wire logic [15:0] cfg_comb,
   input wire logic [15:0] cfg_pin_clk,
   input wire logic [95:0] cfg_borrow,
   input wire logic [15:0] cfg_expand_en,
   input wire logic [47:0] cfg_expand_src,
   input wire logic [15:0] cfg_clr_pair,
   input wire logic [15:0] cfg_route,
   input wire logic [15:0] cfg_is_output,
   input wire logic [15:0] cfg_node_only,
   input wire logic [15:0] cfg_oe_defined,
   input wire logic [39:0] cfg_in_mode,
   input wire logic [4:0] cfg_in_ale,
   input wire logic [7:0] dir_a,
   input wire logic [7:0] dir_b,
   input wire logic [7:0] dir_c,
   input wire logic [7:0] port_a_in,
   input wire logic [7:0] port_b_in,
   input wire logic [7:0] port_c_in,
   output logic [7:0] port_a_out,
   output logic [7:0] port_a_oe,
   output logic [7:0] port_b_out,
   output logic [7:0] port_b_oe,
   output logic [7:0] port_c_out,
   output logic [7:0] port_c_oe,
   output logic [cpm_pkg::NUM_ECS-1:0] external_chip_selects,
   output logic [cpm_pkg::NUM_CELLS-1:0] feedback,
   output logic [cpm_pkg::NUM_IN_CELLS-1:0] input_bus
);
   import cpm_pkg::*;

   // ****************************************
   // Declarations
   // ****************************************
   logic [7:0] pa_meta_reg, pa_sync_reg;
   logic [7:0] pb_meta_reg, pb_sync_reg;
   logic [7:0] pc_meta_reg, pc_sync_reg;
   logic clkpin_meta_reg, clkpin_sync_reg, clkpin_prev_reg;
   logic pin_rise;
   logic [NUM_CELLS-1:0] term_clk_prev_reg;
   logic wr_prev_reg;
   logic [2:0] wr_sel_reg;
   logic [7:0] wr_data_reg;
   logic wr_event;
   logic [2:0] ev_sel;
   logic [7:0] ev_data;
   logic [7:0] mask1_reg, mask2_reg;
   logic [NUM_CELLS-1:0] load_vec;
   logic [NUM_CELLS-1:0] ff_q;
   logic [NUM_CELLS-1:0] cell_out;
   logic [NUM_CELLS-1:0] expand_reg;
   logic [NUM_IN_CELLS-1:0] in_out;
   logic [7:0] read_mux;
   logic [7:0] rdata_reg;
   logic [7:0] pa_out_next, pa_oe_next, pb_out_next, pb_oe_next;
   logic [7:0] pc_out_next, pc_oe_next;
   logic [7:0] pa_out_reg, pa_oe_reg, pb_out_reg, pb_oe_reg;
   logic [7:0] pc_out_reg, pc_oe_reg;
   logic [NUM_ECS-1:0] ecs_reg;
   logic [NUM_CELLS-1:0] drives_pin;
   logic [NUM_CELLS-1:0] cell_oe;
   wire [3:0] nat [NUM_CELLS];
   wire [3:0] keep [NUM_CELLS];
   wire [2:0] req_lo [NUM_CELLS];
   wire [2:0] req_hi [NUM_CELLS];
   wire [2:0] gl [NUM_CELLS];
   wire [2:0] gu [NUM_CELLS];

   // ****************************************
   // Pin synchronisers
   // ****************************************
   // Two flops on every pin input
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pa_meta_reg <= BYTE_ZERO;
         pa_sync_reg <= BYTE_ZERO;
         pb_meta_reg <= BYTE_ZERO;
         pb_sync_reg <= BYTE_ZERO;
         pc_meta_reg <= BYTE_ZERO;
         pc_sync_reg <= BYTE_ZERO;
         clkpin_meta_reg <= 1'b0;
         clkpin_sync_reg <= 1'b0;
         clkpin_prev_reg <= 1'b0;
      end else begin
         pa_meta_reg <= port_a_in;
         pa_sync_reg <= pa_meta_reg;
         pb_meta_reg <= port_b_in;
         pb_sync_reg <= pb_meta_reg;
         pc_meta_reg <= port_c_in;
         pc_sync_reg <= pc_meta_reg;
         clkpin_meta_reg <= cell_clock_pin;
         clkpin_sync_reg <= clkpin_meta_reg;
         clkpin_prev_reg <= clkpin_sync_reg;
      end
   end

   // Rising edge of the cell clock pin
   assign pin_rise = clkpin_sync_reg & ~clkpin_prev_reg;

   // Previous value of each clock term
   always_ff @(posedge clk) begin
      if (sys_rst)
         term_clk_prev_reg <= '0;
      else
         term_clk_prev_reg <= term_in[CLK_BASE +: NUM_CELLS];
   end

   // ****************************************
   // MCU write path
   // ****************************************
   // Capture select and data while strobe is active
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wr_prev_reg <= 1'b0;
         wr_sel_reg <= 3'h0;
         wr_data_reg <= BYTE_ZERO;
      end else begin
         wr_prev_reg <= mcu_wr;
         if (mcu_wr) begin
            wr_sel_reg <= mcu_sel;
            wr_data_reg <= mcu_wdata;
         end
      end
   end

   // Level mode loads each active cycle, edge mode at trailing edge
   assign wr_event = cfg_level_load ? mcu_wr : (wr_prev_reg & ~mcu_wr);
   assign ev_sel = cfg_level_load ? mcu_sel : wr_sel_reg;
   assign ev_data = cfg_level_load ? mcu_wdata : wr_data_reg;

   // Mask registers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         mask1_reg <= MASK_RESET;
         mask2_reg <= MASK_RESET;
      end else if (wr_event && ev_sel == SEL_FIRST_MASK) begin
         mask1_reg <= ev_data;
      end else if (wr_event && ev_sel == SEL_SECOND_MASK) begin
         mask2_reg <= ev_data;
      end
   end

   // Per-cell load strobes gated by the masks
   assign load_vec[7:0] = {8{wr_event && ev_sel == SEL_FIRST_CELLS}}
      & ~mask1_reg;
   assign load_vec[15:8] = {8{wr_event && ev_sel == SEL_SECOND_CELLS}}
      & ~mask2_reg;

   // ****************************************
   // Term allocator and output cells
   // ****************************************
   for (genvar c = 0; c < NUM_CELLS; c++) begin : g_cell
      localparam int K = c % CELLS_PER_GROUP;
      localparam int G = c / CELLS_PER_GROUP;
      localparam int NAT = (G == 0) ? G1_NATIVE : G2_NATIVE;
      localparam int BASE = (G == 0) ? G1_BASE + K * G1_NATIVE
         : G2_BASE + K * G2_NATIVE;
      localparam int BUDGET = (G == 0) ? G1_BORROW
         : (K < 4) ? G2LO_BORROW : G2HI_BORROW;
      localparam logic [3:0] KBIT = 4'(1 << (NAT - 1));
      logic two_in;
      logic [3:0] own_mask;
      logic own_sum, lo_sum, hi_sum, sum_all, k_term;
      logic clk_event, clear_in;
      logic [3:0] exp_idx;

      // Native terms of this cell
      for (genvar j = 0; j < 4; j++) begin : g_nat
         if (j < NAT) begin : g_on
            assign nat[c][j] = term_in[BASE + j];
         end else begin : g_off
            assign nat[c][j] = 1'b0;
         end
      end

      // Borrow requests limited to neighbours and budget
      for (genvar s = 0; s < 3; s++) begin : g_slot
         if (K > 0 && s < BUDGET) begin : g_lo
            assign req_lo[c][s] = cfg_borrow[c * BORROW_SLOTS + s];
         end else begin : g_nlo
            assign req_lo[c][s] = 1'b0;
         end
         if (K < CELLS_PER_GROUP - 1 && 3 + s < BUDGET) begin : g_hi
            assign req_hi[c][s] = cfg_borrow[c * BORROW_SLOTS + 3 + s];
         end else begin : g_nhi
            assign req_hi[c][s] = 1'b0;
         end
         // Grants: lower neighbour first, then upper, then owner
         if (K > 0) begin : g_gl
            assign gl[c][s] = req_hi[c - 1][s];
         end else begin : g_ngl
            assign gl[c][s] = 1'b0;
         end
         if (K < CELLS_PER_GROUP - 1) begin : g_gu
            assign gu[c][s] = req_lo[c + 1][s] & ~gl[c][s];
         end else begin : g_ngu
            assign gu[c][s] = 1'b0;
         end
         assign keep[c][s] = ~gl[c][s] & ~gu[c][s];
      end
      assign keep[c][3] = 1'b1;

      // Borrowed terms granted by the neighbours
      if (K > 0) begin : g_lsum
         assign lo_sum = |(gu[c - 1] & nat[c - 1][2:0]);
      end else begin : g_nlsum
         assign lo_sum = 1'b0;
      end
      if (K < CELLS_PER_GROUP - 1) begin : g_hsum
         assign hi_sum = |(gl[c + 1] & nat[c + 1][2:0]);
      end else begin : g_nhsum
         assign hi_sum = 1'b0;
      end

      // JK and SR use the last native term as second input
      assign two_in = cfg_ff_type[2 * c + 1];
      assign own_mask = two_in ? ~KBIT : 4'hf;
      assign own_sum = |(nat[c] & keep[c] & own_mask);
      assign k_term = nat[c][NAT - 1] & keep[c][NAT - 1];

      // Expansion through a consumed cell of the same group
      assign exp_idx = {G[0], cfg_expand_src[3 * c +: 3]};
      always_ff @(posedge clk) begin
         if (sys_rst)
            expand_reg[c] <= 1'b0;
         else
            expand_reg[c] <= cell_out[exp_idx];
      end
      assign sum_all = own_sum | lo_sum | hi_sum
         | (cfg_expand_en[c] & expand_reg[c]);

      // Clock from pin edge or term edge
      assign clk_event = cfg_pin_clk[c] ? pin_rise
         : (term_in[CLK_BASE + c] & ~term_clk_prev_reg[c]);

      // Clear from one or two terms
      assign clear_in = term_in[CLR_BASE + c]
         | (cfg_clr_pair[c] & term_in[CLR_BASE + (c ^ 1)]);

      cpm_out_cell u_cell (
         .clk(clk),
         .sys_rst(sys_rst),
         .sum_in(sum_all),
         .k_in(k_term),
         .ff_type(cpm_ff_t'(cfg_ff_type[2 * c +: 2])),
         .invert(cfg_invert[c]),
         .comb_sel(cfg_comb[c]),
         .clk_event(clk_event),
         .preset(term_in[PRE_BASE + c]),
         .clear(clear_in),
         .load(load_vec[c]),
         .load_data(ev_data[K]),
         .ff_q(ff_q[c]),
         .cell_out(cell_out[c])
      );

      // Pin use and driver enable
      assign drives_pin[c] = cfg_is_output[c] & ~cfg_node_only[c];
      assign cell_oe[c] = cfg_oe_defined[c] ? term_in[OE_BASE + c]
         : 1'b1;
   end

   // Every cell feeds back into the array, node or not
   assign feedback = cell_out;

   // ****************************************
   // Pin routing
   // ****************************************
   for (genvar n = 0; n < 8; n++) begin : g_pin
      logic a_own, b1_own, b2_own, c_own;
      assign a_own = drives_pin[n] & ~cfg_route[n];
      assign b1_own = drives_pin[n] & cfg_route[n];
      assign b2_own = drives_pin[8 + n] & ~cfg_route[8 + n] & ~b1_own;
      if (n == 2 || n == 3 || n == 4 || n == 7) begin : g_c
         assign c_own = drives_pin[8 + n] & cfg_route[8 + n];
      end else begin : g_nc
         assign c_own = 1'b0;
      end
      assign pa_out_next[n] = a_own & cell_out[n];
      assign pa_oe_next[n] = (a_own & cell_oe[n]) | dir_a[n];
      assign pb_out_next[n] = b1_own ? cell_out[n]
         : (b2_own & cell_out[8 + n]);
      assign pb_oe_next[n] = (b1_own & cell_oe[n])
         | (b2_own & cell_oe[8 + n]) | dir_b[n];
      assign pc_out_next[n] = c_own & cell_out[8 + n];
      assign pc_oe_next[n] = (c_own & cell_oe[8 + n]) | dir_c[n];
   end

   // Registered pin drive
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pa_out_reg <= BYTE_ZERO;
         pa_oe_reg <= BYTE_ZERO;
         pb_out_reg <= BYTE_ZERO;
         pb_oe_reg <= BYTE_ZERO;
         pc_out_reg <= BYTE_ZERO;
         pc_oe_reg <= BYTE_ZERO;
      end else begin
         pa_out_reg <= pa_out_next;
         pa_oe_reg <= pa_oe_next;
         pb_out_reg <= pb_out_next;
         pb_oe_reg <= pb_oe_next;
         pc_out_reg <= pc_out_next;
         pc_oe_reg <= pc_oe_next;
      end
   end
   assign port_a_out = pa_out_reg;
   assign port_a_oe = pa_oe_reg;
   assign port_b_out = pb_out_reg;
   assign port_b_oe = pb_oe_reg;
   assign port_c_out = pc_out_reg;
   assign port_c_oe = pc_oe_reg;

   // Chip selects registered from terms, one cycle late
   always_ff @(posedge clk) begin
      if (sys_rst)
         ecs_reg <= '0;
      else
         ecs_reg <= term_in[ECS_BASE +: NUM_ECS];
   end
   assign external_chip_selects = ecs_reg;

   // ****************************************
   // Input cells
   // ****************************************
   for (genvar q = 0; q < NUM_QUADS; q++) begin : g_quad
      logic [3:0] pins;
      if (q == 0) begin : g_a0
         assign pins = pa_sync_reg[3:0];
      end else if (q == 1) begin : g_a1
         assign pins = pa_sync_reg[7:4];
      end else if (q == 2) begin : g_b0
         assign pins = pb_sync_reg[3:0];
      end else if (q == 3) begin : g_b1
         assign pins = pb_sync_reg[7:4];
      end else begin : g_c
         assign pins = {pc_sync_reg[7], pc_sync_reg[4:2]};
      end
      cpm_in_quad u_quad (
         .clk(clk),
         .sys_rst(sys_rst),
         .pin_in(pins),
         .term_enable(term_in[IN_CLK_BASE + q]),
         .ale(ale),
         .use_ale(cfg_in_ale[q]),
         .mode_bits(cfg_in_mode[8 * q +: 8]),
         .cell_out(in_out[4 * q +: 4])
      );
   end
   assign input_bus = in_out;

   // ****************************************
   // MCU read path
   // ****************************************
   always_comb begin
      case (mcu_sel)
         SEL_FIRST_CELLS: read_mux = ff_q[7:0];
         SEL_SECOND_CELLS: read_mux = ff_q[15:8];
         SEL_FIRST_MASK: read_mux = mask1_reg;
         SEL_SECOND_MASK: read_mux = mask2_reg;
         SEL_INPUT_A: read_mux = in_out[7:0];
         SEL_INPUT_B: read_mux = in_out[15:8];
         SEL_INPUT_C: read_mux = {in_out[19], 2'b00, in_out[18:16], 2'b00};
         default: read_mux = BYTE_ZERO;
      endcase
   end

   // Read data register, zero when no read
   always_ff @(posedge clk) begin
      if (sys_rst)
         rdata_reg <= BYTE_ZERO;
      else
         rdata_reg <= mcu_rd ? read_mux : BYTE_ZERO;
   end
   assign mcu_rdata = rdata_reg;
endmodule // cpm_macrocell_array
`default_nettype wire

// >>> cpm_pkg.sv
// Shared constants and types of the macrocell array
`default_nettype none
package cpm_pkg;
   // ****************************************
   // Array dimensions
   // ****************************************
   localparam int NUM_TERMS = 137;
   localparam int CELLS_PER_GROUP = 8;
   localparam int NUM_CELLS = 16;
   localparam int NUM_IN_CELLS = 20;
   localparam int NUM_QUADS = 5;
   localparam int NUM_ECS = 2;
   localparam int BORROW_SLOTS = 6;
   // ****************************************
   // Product term budgets
   // ****************************************
   localparam int G1_NATIVE = 3;
   localparam int G2_NATIVE = 4;
   localparam int G1_BORROW = 6;
   localparam int G2LO_BORROW = 5;
   localparam int G2HI_BORROW = 6;
   // ****************************************
   // Product term index map
   // ****************************************
   localparam int G1_BASE = 0;
   localparam int G2_BASE = 24;
   localparam int OE_BASE = 56;
   localparam int CLK_BASE = 72;
   localparam int PRE_BASE = 88;
   localparam int CLR_BASE = 104;
   localparam int IN_CLK_BASE = 120;
   localparam int ECS_BASE = 125;
   // ****************************************
   // MCU register select codes
   // ****************************************
   localparam logic [2:0] SEL_FIRST_CELLS = 3'h0;
   localparam logic [2:0] SEL_SECOND_CELLS = 3'h1;
   localparam logic [2:0] SEL_FIRST_MASK = 3'h2;
   localparam logic [2:0] SEL_SECOND_MASK = 3'h3;
   localparam logic [2:0] SEL_INPUT_A = 3'h4;
   localparam logic [2:0] SEL_INPUT_B = 3'h5;
   localparam logic [2:0] SEL_INPUT_C = 3'h6;
   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [7:0] MASK_RESET = 8'h00;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [1:0] {
      FF_D = 2'b00,
      FF_T = 2'b01,
      FF_JK = 2'b10,
      FF_SR = 2'b11
   } cpm_ff_t;
   typedef enum logic [1:0] {
      IN_PASS = 2'b00,
      IN_LATCH = 2'b01,
      IN_REG = 2'b10
   } cpm_in_mode_t;
endpackage
`default_nettype wire

// >>> cpm_out_cell.sv
// One output macrocell: polarity, storage element and output select
`timescale 1ns/1ns
`default_nettype none
module cpm_out_cell (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic sum_in,
   input wire logic k_in,
   input wire cpm_pkg::cpm_ff_t ff_type,
   input wire logic invert,
   input wire logic comb_sel,
   input wire logic clk_event,
   input wire logic preset,
   input wire logic clear,
   input wire logic load,
   input wire logic load_data,
   output logic ff_q,
   output logic cell_out
);
   import cpm_pkg::*;
   logic xor_out;
   logic ff_reg;
   logic ff_next;

   // Polarity inverter on the summed terms
   assign xor_out = sum_in ^ invert;

   // Next state per storage type
   always_comb begin
      ff_next = ff_reg;
      case (ff_type)
         FF_D: ff_next = xor_out;
         FF_T: ff_next = ff_reg ^ xor_out;
         FF_JK: ff_next = (xor_out & ~ff_reg) | (~k_in & ff_reg);
         FF_SR: ff_next = xor_out | (ff_reg & ~k_in);
         default: ff_next = ff_reg;
      endcase
   end

   // MCU load first, then clear, preset, clock
   always_ff @(posedge clk) begin
      if (sys_rst)
         ff_reg <= 1'b0;
      else if (load)
         ff_reg <= load_data;
      else if (clear)
         ff_reg <= 1'b0;
      else if (preset)
         ff_reg <= 1'b1;
      else if (clk_event)
         ff_reg <= ff_next;
   end

   // Registered or combinational result
   assign ff_q = ff_reg;
   assign cell_out = comb_sel ? xor_out : ff_reg;
endmodule // cpm_out_cell
`default_nettype wire

// >>> cpm_in_quad.sv
// Four input macrocells sharing one latch enable or register clock
`timescale 1ns/1ns
`default_nettype none
module cpm_in_quad (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [3:0] pin_in,
   input wire logic term_enable,
   input wire logic ale,
   input wire logic use_ale,
   input wire logic [7:0] mode_bits,
   output logic [3:0] cell_out
);
   import cpm_pkg::*;
   logic enable;
   logic en_prev_reg;
   logic en_rise;
   logic [3:0] hold_reg;

   // Enable source: product term or address strobe
   assign enable = use_ale ? ale : term_enable;
   assign en_rise = enable & ~en_prev_reg;

   // Edge detect of the shared enable
   always_ff @(posedge clk) begin
      if (sys_rst)
         en_prev_reg <= 1'b0;
      else
         en_prev_reg <= enable;
   end

   // Per cell latch, register or pass-through
   for (genvar i = 0; i < 4; i++) begin : g_cell
      cpm_in_mode_t mode;
      assign mode = cpm_in_mode_t'(mode_bits[2*i +: 2]);
      always_ff @(posedge clk) begin
         if (sys_rst)
            hold_reg[i] <= 1'b0;
         else if ((mode == IN_LATCH && enable) || (mode == IN_REG && en_rise))
            hold_reg[i] <= pin_in[i];
      end
      always_comb begin
         case (mode)
            IN_LATCH: cell_out[i] = enable ? pin_in[i] : hold_reg[i];
            IN_REG: cell_out[i] = hold_reg[i];
            default: cell_out[i] = pin_in[i];
         endcase
      end
   end
endmodule // cpm_in_quad
`default_nettype wire

// >>> cpm_macrocell_array_monitor.sv
// Port checker for the macrocell array
`timescale 1ns/1ns
`default_nettype none
module cpm_macrocell_array_monitor (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [cpm_pkg::NUM_TERMS-1:0] term_in,
   input wire logic [2:0] mcu_sel,
   input wire logic mcu_rd,
   input wire logic [7:0] mcu_rdata,
   input wire logic [39:0] cfg_in_mode,
   input wire logic [7:0] dir_a,
   input wire logic [7:0] dir_c,
   input wire logic [7:0] port_a_in,
   input wire logic [7:0] port_a_oe,
   input wire logic [7:0] port_c_out,
   input wire logic [7:0] port_c_oe,
   input wire logic [cpm_pkg::NUM_ECS-1:0] external_chip_selects,
   input wire logic [cpm_pkg::NUM_IN_CELLS-1:0] input_bus
);
   import cpm_pkg::*;
   // One clock domain, reset masks every check
   default clocking dc @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   // Read path checks
   rd_idle_zero_a: assert property (!$past(mcu_rd)
      |-> mcu_rdata == 8'h00)
      else $error("read data not zero while idle");
   bad_sel_zero_a: assert property (mcu_rd && mcu_sel == 3'h7
      |=> mcu_rdata == 8'h00)
      else $error("unused select read not zero");
   in_a_read_a: assert property (mcu_rd && mcu_sel == SEL_INPUT_A
      |=> mcu_rdata == $past(input_bus[7:0]))
      else $error("input port A read mismatch");
   port_c_read_a: assert property (mcu_rd && mcu_sel == SEL_INPUT_C
      |=> mcu_rdata[6:5] == 2'b00 && mcu_rdata[1:0] == 2'b00)
      else $error("port C read shows absent cells");
   // Pin side checks
   chip_sel_a: assert property (!$past(sys_rst)
      |-> external_chip_selects == $past(term_in[ECS_BASE+1:ECS_BASE]))
      else $error("chip selects do not follow terms");
   dir_oe_a: assert property (!$past(sys_rst)
      |-> (port_a_oe & $past(dir_a)) == $past(dir_a))
      else $error("direction bit does not enable driver");
   free_pin_a: assert property (!$past(sys_rst)
      |-> port_c_out[1:0] == 2'b00 && port_c_oe[1:0] == $past(dir_c[1:0]))
      else $error("port C pin without cell misbehaves");
   pass_in_a: assert property (cfg_in_mode[1:0] == 2'b00
      && !$past(sys_rst) && !$past(sys_rst, 2)
      |-> input_bus[0] == $past(port_a_in[0], 2))
      else $error("pass-through input cell mismatch");
   cov_in_read: cover property (mcu_rd && mcu_sel == SEL_INPUT_A);
   cov_c_read: cover property (mcu_rd && mcu_sel == SEL_INPUT_C);
   cov_chip_sel: cover property (external_chip_selects != 2'b00);
endmodule // cpm_macrocell_array_monitor
bind cpm_macrocell_array cpm_macrocell_array_monitor u_mon (.clk, .sys_rst,
   .term_in, .mcu_sel, .mcu_rd, .mcu_rdata, .cfg_in_mode, .dir_a, .dir_c,
   .port_a_in, .port_a_oe, .port_c_out, .port_c_oe, .external_chip_selects,
   .input_bus);
`default_nettype wire

// >>> cpm_mcu_model.sv
// Behavioural MCU core on the internal data bus
`timescale 1ns/1ns
`default_nettype none
module cpm_mcu_model (
   input wire logic clk,
   output logic [2:0] mcu_sel,
   output logic mcu_wr,
   output logic mcu_rd,
   output logic [7:0] mcu_wdata,
   input wire logic [7:0] mcu_rdata
);
   // Bus idle at time zero
   initial begin
      mcu_sel = 3'h7;
      mcu_wr = 1'b0;
      mcu_rd = 1'b0;
      mcu_wdata = 8'h00;
   end
   // Write: strobe one cycle, then one idle cycle
   task automatic wr_reg(input logic [2:0] sel, input logic [7:0] d);
      @(negedge clk);
      mcu_sel = sel;
      mcu_wdata = d;
      mcu_wr = 1'b1;
      @(negedge clk);
      mcu_wr = 1'b0;
      mcu_wdata = ~d; // Released bus shows no stale data
      @(negedge clk);
   endtask
   // Read: strobe one cycle, data stands the next
   task automatic rd_reg(input logic [2:0] sel, output logic [7:0] d);
      @(negedge clk);
      mcu_sel = sel;
      mcu_rd = 1'b1;
      @(negedge clk);
      mcu_rd = 1'b0;
      d = mcu_rdata;
   endtask
endmodule // cpm_mcu_model
`default_nettype wire

// >>> test_cpm_macrocell_array.sv
// Self-checking bench for the macrocell array
`timescale 1ns/1ns
`default_nettype none
module test_cpm_macrocell_array;
   import cpm_pkg::*;
   logic clk = 1'b0, sys_rst = 1'b1, ale = 1'b0, cfg_level_load = 1'b0;
   logic [NUM_TERMS-1:0] term_in = '0;
   logic [15:0] cfg_invert = 16'h0000, cfg_comb = 16'h0000;
   logic [15:0] cfg_oe_defined = 16'h0000, cfg_is_output = 16'hFFFF;
   logic [15:0] cfg_pin_clk = 16'h0000, cfg_expand_en = 16'h0000;
   logic [15:0] cfg_clr_pair = 16'h0000, cfg_route = 16'h0000;
   logic [15:0] cfg_node_only = 16'h0000;
   logic [39:0] cfg_in_mode = 40'h00_0000_0000;
   logic [4:0] cfg_in_ale = 5'h00;
   logic [7:0] dir_a = 8'h00, dir_b = 8'h00, dir_c = 8'h00;
   logic [7:0] port_a_in = 8'h00, port_b_in = 8'h00, port_c_in = 8'h00;
   logic [2:0] mcu_sel;
   logic mcu_wr, mcu_rd;
   logic [7:0] mcu_wdata, mcu_rdata, port_a_out, port_a_oe, port_b_out;
   logic [NUM_ECS-1:0] external_chip_selects;
   logic [7:0] port_b_oe;
   logic [15:0] feedback;
   logic [31:0] cfg_ff_type = 32'h0000_0000;
   logic cell_clock_pin = 1'b0;
   int err_total = 0, n_compared = 0, cycles = 0;
   // Clock at 125 MHz
   always #4 clk = ~clk;
   cpm_mcu_model u_cpm_mcu_model (.clk, .mcu_sel, .mcu_wr, .mcu_rd,
      .mcu_wdata, .mcu_rdata);
   cpm_macrocell_array u_cpm_macrocell_array (.clk, .sys_rst, .term_in,
      .cell_clock_pin, .ale, .mcu_sel, .mcu_wr, .mcu_rd, .mcu_wdata,
      .mcu_rdata, .cfg_level_load, .cfg_ff_type, .cfg_invert,
      .cfg_comb, .cfg_pin_clk, .cfg_borrow(96'h0), .cfg_expand_en,
      .cfg_expand_src(48'h0), .cfg_clr_pair, .cfg_route, .cfg_is_output,
      .cfg_node_only, .cfg_oe_defined, .cfg_in_mode, .cfg_in_ale, .dir_a,
      .dir_b, .dir_c, .port_a_in, .port_b_in, .port_c_in, .port_a_out,
      .port_a_oe, .port_b_out, .port_b_oe, .port_c_out(), .port_c_oe(),
      .external_chip_selects, .feedback, .input_bus());
   // Verdict and end of run
   task automatic give_verdict();
      $display("Compared %0d, mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // Compare one byte
   task automatic chk(input string nm, input logic [7:0] e,
      input logic [7:0] g);
      n_compared++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Read a register and compare
   task automatic rd_chk(input logic [2:0] s, input logic [7:0] e,
      input string nm);
      logic [7:0] d;
      u_cpm_mcu_model.rd_reg(s, d);
      chk(nm, e, d);
   endtask
   // Hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 2000) begin
         err_total++;
         give_verdict();
      end
   end
   // Main sequence
   initial begin
      repeat (10) @(negedge clk);
      sys_rst = 1'b0;
      rd_chk(SEL_FIRST_MASK, 8'h00, "first mask");
      rd_chk(SEL_SECOND_MASK, 8'h00, "second mask");
      chk("oe a", 8'hFF, port_a_oe);
      u_cpm_mcu_model.wr_reg(SEL_FIRST_CELLS, 8'h55);
      u_cpm_mcu_model.wr_reg(SEL_SECOND_CELLS, 8'hA3);
      rd_chk(SEL_FIRST_CELLS, 8'h55, "first cells");
      rd_chk(SEL_SECOND_CELLS, 8'hA3, "second cells");
      chk("pins a", 8'h55, port_a_out);
      chk("pins b", 8'hA3, port_b_out);
      u_cpm_mcu_model.wr_reg(SEL_FIRST_MASK, 8'h0F);
      rd_chk(SEL_FIRST_MASK, 8'h0F, "mask set");
      u_cpm_mcu_model.wr_reg(SEL_FIRST_CELLS, 8'hFF);
      rd_chk(SEL_FIRST_CELLS, 8'hF5, "masked load");
      cfg_level_load = 1'b1;
      u_cpm_mcu_model.wr_reg(SEL_SECOND_MASK, 8'hF0);
      u_cpm_mcu_model.wr_reg(SEL_SECOND_CELLS, 8'h0C);
      rd_chk(SEL_SECOND_CELLS, 8'hAC, "level load");
      cfg_oe_defined = 16'hFFFF;
      dir_a = 8'h81;
      term_in[OE_BASE+1] = 1'b1;
      term_in[ECS_BASE] = 1'b1;
      repeat (3) @(negedge clk);
      chk("oe term", 8'h83, port_a_oe);
      chk("chip sel", 8'h01, {6'h00, external_chip_selects});
      port_a_in = 8'h3C;
      port_c_in = 8'hFF;
      repeat (3) @(negedge clk);
      rd_chk(SEL_INPUT_A, 8'h3C, "input a");
      rd_chk(SEL_INPUT_C, 8'h9C, "input c");
      rd_chk(3'h7, 8'h00, "unused sel");
      cfg_in_mode[7:0] = 8'hAA;
      cfg_in_ale[0] = 1'b1;
      ale = 1'b1;
      repeat (2) @(negedge clk);
      ale = 1'b0;
      port_a_in = 8'hC3;
      repeat (3) @(negedge clk);
      rd_chk(SEL_INPUT_A, 8'hCC, "ale capture");
      cfg_comb[1] = 1'b1;
      cfg_invert[1] = 1'b1;
      repeat (3) @(negedge clk);
      chk("inverted comb", 8'hF7, port_a_out);
      chk("feedback", 8'hF7, feedback[7:0]);
      chk("oe b", 8'h00, port_b_oe);
      // Cell 8 as T flop clocked by one rising edge of the clock pin
      cfg_ff_type[17:16] = 2'b01;
      cfg_pin_clk[8] = 1'b1;
      term_in[G2_BASE] = 1'b1;
      cell_clock_pin = 1'b1;
      repeat (4) @(negedge clk);
      rd_chk(SEL_SECOND_CELLS, 8'hAD, "pin toggle");
      // Preset cell 9, clear cell 10, cell 11 cleared through its pair
      term_in[PRE_BASE+9] = 1'b1;
      term_in[CLR_BASE+10] = 1'b1;
      cfg_clr_pair[11] = 1'b1;
      repeat (2) @(negedge clk);
      rd_chk(SEL_SECOND_CELLS, 8'hA3, "preset clear");
      give_verdict();
   end
endmodule // test_cpm_macrocell_array
`default_nettype wire
